/* File: verilog/dpd_map.svh */
// register map and ramp counts of the playback path
//Function
//- converter enables live in power register and mirror at volume bit 15
//- volume code zero mutes, code one -71.625dB, 0.375dB steps, 0xc0 unity
//- volume stays pending until a one hits either update bit
//- soft mute lowers gain gradually towards silence
//- soft mute bit comes out of reset set
//- un-mute jumps to volume when mode zero, ramps when mode one
//- ramp rate bit zero steps at fs/2, one steps at fs/32
//- de-emphasis field 00 off, 01 32k, 10 44.1k, 11 48k
//- mono bit gives both channels half of left plus right
//- mono mix acts only while both converters are enabled
//- per-channel polarity bits invert that channel's samples
//- filter select bit picks normal or sloping stopband response
//- samples carried with 24-bit precision to the modulators
//- path works at any sample rate from 8 to 48 kHz
`ifndef DPD_MAP_SVH
`define DPD_MAP_SVH
// word indices; byte address = 4 * index
`define DPD_IDX_POWER       6'h0b
`define DPD_IDX_CONTROL     6'h30
`define DPD_IDX_VOL_LEFT    6'h32
`define DPD_IDX_VOL_RIGHT   6'h33
`define DPD_IDX_MUTE        6'h3a
`define DPD_IDX_MUTE_VOL    6'h3b
`define DPD_IDX_GAIN_STAT   6'h3c
`define DPD_IDX_RAMP_STAT   6'h3d
// field positions
`define DPD_BIT_LEFT_ON     4
`define DPD_BIT_RIGHT_ON    5
`define DPD_BIT_VOL_ON      15
`define DPD_BIT_COMMIT      8
`define DPD_BIT_SOFT_MUTE   14
`define DPD_BIT_UNSIL_MODE  14
`define DPD_BIT_RAMP_SPEED  13
`define DPD_BIT_STOPBAND    12
`define DPD_BIT_MONO        13
`define DPD_BIT_LEFT_FLIP   1
`define DPD_BIT_RIGHT_FLIP  0
// reset values
`define DPD_RST_POWER       16'h0000
`define DPD_RST_CONTROL     16'h0000
`define DPD_RST_GAIN        8'hc0
`define DPD_RST_MUTE        16'h4000
`define DPD_RST_MUTE_VOL    16'h0000
// ramp: 256 steps, one step per 2 or per 32 samples
`define DPD_RAMP_FULL       9'h100
`define DPD_RAMP_FAST_SMP   5'h01
`define DPD_RAMP_SLOW_SMP   5'h1f
`endif

/* File: verilog/dpd_pkg.sv */
// types of the playback path
package dpd_pkg;
   // one stereo sample pair, 24-bit signed per channel
   typedef struct packed {
      logic signed [23:0] left;
      logic signed [23:0] right;
   } dpd_stereo_t;
   // soft mute ramp states
   typedef enum logic [3:0] {
      DPD_FULL   = 4'h1,
      DPD_DOWN   = 4'h2,
      DPD_SILENT = 4'h4,
      DPD_UP     = 4'h8
   } dpd_ramp_state_t;
endpackage : dpd_pkg

/* File: verilog/dpd_playback_path.sv */
// playback path: registers, mono, polarity, de-emphasis, volume, soft mute
`timescale 1ns/10ps
`include "dpd_map.svh"
module dpd_playback_path (
   input  wire logic               clk_in,
   input  wire logic               resetn_in,
   // classic wishbone slave
   input  wire logic               wb_cyc_in,
   input  wire logic               wb_stb_in,
   input  wire logic               wb_we_in,
   input  wire logic [7:0]         wb_adr_in,
   input  wire logic [3:0]         wb_sel_in,
   input  wire logic [31:0]        wb_dat_in,
   output logic      [31:0]        wb_dat_out,
   output logic                    wb_ack_out,
   // samples from the audio interface
   input  wire dpd_pkg::dpd_stereo_t smp_in,
   input  wire logic               smp_valid_in,
   output logic                    smp_ready_out,
   // samples towards the interpolators
   output dpd_pkg::dpd_stereo_t    smp_out,
   output logic                    smp_valid_out,
   input  wire logic               smp_ready_in,
   output logic                    sloping_stopband_select_out
);

   logic [15:0] power_reg;
   logic [15:0] control_reg;
   logic [15:0] mute_reg;
   logic [15:0] mute_vol_reg;
   logic [7:0]  pend_gain_reg [2];
   logic [7:0]  act_gain_reg  [2];
   logic        ack_reg;
   logic [31:0] rdat_reg;
   logic [8:0]  ramp_reg;
   logic [4:0]  tick_cnt_reg;
   dpd_pkg::dpd_ramp_state_t ramp_state_reg;
   logic signed [23:0] lp_reg [2];
   dpd_pkg::dpd_stereo_t buf_mem [2];
   logic        wr_ptr_reg;
   logic        rd_ptr_reg;
   logic [1:0]  count_reg;

   // control field views
   logic        left_converter_on;
   logic        right_converter_on;
   logic        soft_mute;
   logic        unsilence_ramp_mode;
   logic        silence_ramp_speed;
   logic [1:0]  emphasis_undo_select;
   logic        mono_mix;
   logic        left_sign_flip;
   logic        right_sign_flip;

   assign left_converter_on    = power_reg[`DPD_BIT_LEFT_ON];
   assign right_converter_on   = power_reg[`DPD_BIT_RIGHT_ON];
   assign soft_mute            = mute_reg[`DPD_BIT_SOFT_MUTE];
   assign unsilence_ramp_mode  = mute_vol_reg[`DPD_BIT_UNSIL_MODE];
   assign silence_ramp_speed   = mute_vol_reg[`DPD_BIT_RAMP_SPEED];
   assign emphasis_undo_select = control_reg[5:4];
   assign mono_mix             = control_reg[`DPD_BIT_MONO];
   assign left_sign_flip       = control_reg[`DPD_BIT_LEFT_FLIP];
   assign right_sign_flip      = control_reg[`DPD_BIT_RIGHT_FLIP];
   assign sloping_stopband_select_out = mute_vol_reg[`DPD_BIT_STOPBAND];

   // merge a write under the byte enables
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [15:0] wd,
                                           input logic [1:0]  sel);
      merge16 = {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
   endfunction : merge16

   // volume code to linear gain; 16 codes make 6dB so the top nibble is a shift
   function automatic logic [26:0] gain_decode(input logic [7:0] code);
      logic [11:0] mant;
      mant = 12'h800;
      case (code[3:0])
         4'h0: mant = 12'h800;
         4'h1: mant = 12'h85b;
         4'h2: mant = 12'h8b9;
         4'h3: mant = 12'h91c;
         4'h4: mant = 12'h983;
         4'h5: mant = 12'h9ef;
         4'h6: mant = 12'ha60;
         4'h7: mant = 12'had6;
         4'h8: mant = 12'hb50;
         4'h9: mant = 12'hbd1;
         4'ha: mant = 12'hc56;
         4'hb: mant = 12'hce2;
         4'hc: mant = 12'hd74;
         4'hd: mant = 12'he0d;
         4'he: mant = 12'heac;
         default: mant = 12'hf52;
      endcase
      // code 0 mutes; 0xc0 is unity, 0x800 shifted by 12
      if (code == 8'h00) begin
         gain_decode = 27'h0000000;
      end else begin
         gain_decode = 27'(mant) << code[7:4];
      end
   endfunction : gain_decode

   // clamp a wide signed value to 24 bits
   function automatic logic signed [23:0] sat24(input logic signed [52:0] v);
      if (v > 53'sh7fffff) begin
         sat24 = 24'sh7fffff;
      end else if (v < -53'sh800000) begin
         sat24 = -24'sh800000;
      end else begin
         sat24 = v[23:0];
      end
   endfunction : sat24

   // bus decode
   logic        bus_req;
   logic        bus_wr;
   logic [5:0]  bus_idx;
   logic [1:0]  bus_sel;
   logic [15:0] bus_wd;
   logic        commit_wr;
   assign bus_req   = wb_cyc_in & wb_stb_in & ~ack_reg;
   assign bus_wr    = bus_req & wb_we_in;
   assign bus_idx   = wb_adr_in[7:2];
   assign bus_sel   = wb_sel_in[1:0];
   assign bus_wd    = wb_dat_in[15:0];
   // the update bit of either volume register commits both channels
   assign commit_wr = bus_wr & bus_sel[1] & bus_wd[`DPD_BIT_COMMIT] &
                      (bus_idx == `DPD_IDX_VOL_LEFT || bus_idx == `DPD_IDX_VOL_RIGHT);

   // ack one cycle after the request, for one cycle
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= bus_req;
      end
   end
   assign wb_ack_out = ack_reg;
   assign wb_dat_out = rdat_reg;

   // power register; enables also reachable through volume bit 15
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         power_reg <= `DPD_RST_POWER;
      end else if (bus_wr && bus_idx == `DPD_IDX_POWER) begin
         power_reg <= merge16(power_reg, bus_wd, bus_sel);
      end else if (bus_wr && bus_sel[1] && bus_idx == `DPD_IDX_VOL_LEFT) begin
         power_reg[`DPD_BIT_LEFT_ON] <= bus_wd[`DPD_BIT_VOL_ON];
      end else if (bus_wr && bus_sel[1] && bus_idx == `DPD_IDX_VOL_RIGHT) begin
         power_reg[`DPD_BIT_RIGHT_ON] <= bus_wd[`DPD_BIT_VOL_ON];
      end
   end

   // plain control registers
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         control_reg  <= `DPD_RST_CONTROL;
         mute_reg     <= `DPD_RST_MUTE;
         mute_vol_reg <= `DPD_RST_MUTE_VOL;
      end else if (bus_wr) begin
         if (bus_idx == `DPD_IDX_CONTROL) begin
            control_reg <= merge16(control_reg, bus_wd, bus_sel);
         end
         if (bus_idx == `DPD_IDX_MUTE) begin
            mute_reg <= merge16(mute_reg, bus_wd, bus_sel);
         end
         if (bus_idx == `DPD_IDX_MUTE_VOL) begin
            mute_vol_reg <= merge16(mute_vol_reg, bus_wd, bus_sel);
         end
      end
   end

   // pending and active volume; a commit uses the value written with it
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pend_gain_reg[0] <= `DPD_RST_GAIN;
         pend_gain_reg[1] <= `DPD_RST_GAIN;
         act_gain_reg[0]  <= `DPD_RST_GAIN;
         act_gain_reg[1]  <= `DPD_RST_GAIN;
      end else begin
         if (bus_wr && bus_sel[0] && bus_idx == `DPD_IDX_VOL_LEFT) begin
            pend_gain_reg[0] <= bus_wd[7:0];
         end
         if (bus_wr && bus_sel[0] && bus_idx == `DPD_IDX_VOL_RIGHT) begin
            pend_gain_reg[1] <= bus_wd[7:0];
         end
         if (commit_wr) begin
            act_gain_reg[0] <= (bus_sel[0] && bus_idx == `DPD_IDX_VOL_LEFT) ?
                               bus_wd[7:0] : pend_gain_reg[0];
            act_gain_reg[1] <= (bus_sel[0] && bus_idx == `DPD_IDX_VOL_RIGHT) ?
                               bus_wd[7:0] : pend_gain_reg[1];
         end
      end
   end

   // read mux; unmapped words and the update bit read zero
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rdat_reg <= 32'h00000000;
      end else if (bus_req && !wb_we_in) begin
         case (bus_idx)
            `DPD_IDX_POWER:     rdat_reg <= {16'h0000, power_reg};
            `DPD_IDX_CONTROL:   rdat_reg <= {16'h0000, control_reg};
            `DPD_IDX_VOL_LEFT:  rdat_reg <= {16'h0000, left_converter_on, 7'h00,
                                             pend_gain_reg[0]};
            `DPD_IDX_VOL_RIGHT: rdat_reg <= {16'h0000, right_converter_on, 7'h00,
                                             pend_gain_reg[1]};
            `DPD_IDX_MUTE:      rdat_reg <= {16'h0000, mute_reg};
            `DPD_IDX_MUTE_VOL:  rdat_reg <= {16'h0000, mute_vol_reg};
            `DPD_IDX_GAIN_STAT: rdat_reg <= {16'h0000, act_gain_reg[1], act_gain_reg[0]};
            `DPD_IDX_RAMP_STAT: rdat_reg <= {16'h0000, 3'h0, ramp_state_reg, ramp_reg};
            default:            rdat_reg <= 32'h00000000;
         endcase
      end else begin
         rdat_reg <= 32'h00000000;
      end
   end

   // sample handshake: take only while the buffer has room
   logic smp_take;
   logic buf_pop;
   assign smp_ready_out = (count_reg != 2'h2);
   assign smp_take      = smp_valid_in & smp_ready_out;
   assign buf_pop       = smp_valid_out & smp_ready_in;

   // ramp pacing: a step every 2 or 32 taken samples, free of fs
   logic ramp_tick;
   assign ramp_tick = smp_take && (tick_cnt_reg == (silence_ramp_speed ?
                      `DPD_RAMP_SLOW_SMP : `DPD_RAMP_FAST_SMP));
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         tick_cnt_reg <= 5'h00;
      end else if (ramp_tick) begin
         tick_cnt_reg <= 5'h00;
      end else if (smp_take) begin
         tick_cnt_reg <= tick_cnt_reg + 5'h01;
      end
   end

   // soft mute state machine; silent from reset as mute is set
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ramp_state_reg <= dpd_pkg::DPD_SILENT;
         ramp_reg       <= 9'h000;
      end else begin
         case (ramp_state_reg)
            dpd_pkg::DPD_FULL: begin
               ramp_reg <= `DPD_RAMP_FULL;
               if (soft_mute) begin
                  ramp_state_reg <= dpd_pkg::DPD_DOWN;
               end
            end
            dpd_pkg::DPD_DOWN: begin
               if (!soft_mute) begin
                  if (unsilence_ramp_mode) begin
                     ramp_state_reg <= dpd_pkg::DPD_UP;
                  end else begin
                     ramp_state_reg <= dpd_pkg::DPD_FULL;
                     ramp_reg       <= `DPD_RAMP_FULL;
                  end
               end else if (ramp_reg == 9'h000) begin
                  ramp_state_reg <= dpd_pkg::DPD_SILENT;
               end else if (ramp_tick) begin
                  ramp_reg <= ramp_reg - 9'h001;
               end
            end
            dpd_pkg::DPD_SILENT: begin
               if (!soft_mute) begin
                  if (unsilence_ramp_mode) begin
                     ramp_state_reg <= dpd_pkg::DPD_UP;
                  end else begin
                     ramp_state_reg <= dpd_pkg::DPD_FULL;
                     ramp_reg       <= `DPD_RAMP_FULL;
                  end
               end
            end
            dpd_pkg::DPD_UP: begin
               if (soft_mute) begin
                  ramp_state_reg <= dpd_pkg::DPD_DOWN;
               end else if (ramp_reg == `DPD_RAMP_FULL) begin
                  ramp_state_reg <= dpd_pkg::DPD_FULL;
               end else if (ramp_tick) begin
                  ramp_reg <= ramp_reg + 9'h001;
               end
            end
            default: begin
               ramp_state_reg <= dpd_pkg::DPD_SILENT;
               ramp_reg       <= 9'h000;
            end
         endcase
      end
   end

   // mono mix before per-channel work; needs both converters on
   logic               both_on;
   logic signed [24:0] mono_sum;
   logic signed [23:0] chan_in [2];
   logic               chan_on [2];
   logic               chan_flip [2];
   dpd_pkg::dpd_stereo_t proc_pair;
   assign both_on  = left_converter_on & right_converter_on;
   assign mono_sum = (25'(smp_in.left) + 25'(smp_in.right)) >>> 1;
   assign chan_in[0] = (mono_mix && both_on) ? mono_sum[23:0] : smp_in.left;
   assign chan_in[1] = (mono_mix && both_on) ? mono_sum[23:0] : smp_in.right;
   assign chan_on[0]   = left_converter_on;
   assign chan_on[1]   = right_converter_on;
   assign chan_flip[0] = left_sign_flip;
   assign chan_flip[1] = right_sign_flip;

   // per-channel datapath: polarity, de-emphasis, volume, soft mute ramp
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
         logic signed [24:0] flipped;
         logic signed [24:0] lp_diff;
         logic signed [24:0] lp_next;
         logic signed [24:0] emph_out;
         logic signed [52:0] vol_prod;
         logic signed [23:0] vol_out;
         logic signed [52:0] ramp_prod;
         logic [4:0]         lp_shift;
         // sign flip; the most negative code clamps to full positive
         assign flipped = chan_flip[ch] ? -25'(chan_in[ch]) : 25'(chan_in[ch]);
         // first-order shelf; a shallower corner for the higher rates
         always_comb begin
            case (emphasis_undo_select)
               2'h1:    lp_shift = 5'h02;
               2'h2:    lp_shift = 5'h03;
               2'h3:    lp_shift = 5'h03;
               default: lp_shift = 5'h00;
            endcase
         end
         assign lp_diff  = flipped - 25'(lp_reg[ch]);
         assign lp_next  = 25'(lp_reg[ch]) + (lp_diff >>> lp_shift);
         assign emph_out = (emphasis_undo_select == 2'h0) ? flipped :
                           (flipped + lp_next) >>> 1;
         // gain at 2^23 scale, 24-bit result carried to the interpolator
         assign vol_prod  = (53'(emph_out) * $signed(53'(gain_decode(act_gain_reg[ch]))))
                            >>> 23;
         assign vol_out   = sat24(vol_prod);
         assign ramp_prod = (53'(vol_out) * $signed(53'(ramp_reg))) >>> 8;
         always_ff @(posedge clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
               lp_reg[ch] <= 24'sh000000;
            end else if (smp_take) begin
               lp_reg[ch] <= sat24(53'(lp_next));
            end
         end
      end
   endgenerate
   assign proc_pair = {chan_on[0] ? sat24(g_chan[0].ramp_prod) : 24'sh000000,
                       chan_on[1] ? sat24(g_chan[1].ramp_prod) : 24'sh000000};

   // two-entry buffer: a stalled receiver holds the source off without loss
   always_ff @(posedge clk_in) begin
      if (smp_take) begin
         buf_mem[wr_ptr_reg] <= proc_pair;
      end
   end
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         count_reg  <= 2'h0;
      end else begin
         if (smp_take) begin
            wr_ptr_reg <= ~wr_ptr_reg;
         end
         if (buf_pop) begin
            rd_ptr_reg <= ~rd_ptr_reg;
         end
         count_reg <= count_reg + {1'b0, smp_take} - {1'b0, buf_pop};
      end
   end
   assign smp_valid_out = (count_reg != 2'h0);
   assign smp_out       = smp_valid_out ? buf_mem[rd_ptr_reg] : '0;

endmodule : dpd_playback_path

/* File: testbench/dpd_playback_path_asserts.sv */
// port-level checks of the playback path
`timescale 1ns/10ps
module dpd_playback_path_asserts (
   input wire logic                 clk_in,
   input wire logic                 resetn_in,
   input wire logic                 wb_cyc_in,
   input wire logic                 wb_stb_in,
   input wire logic                 wb_we_in,
   input wire logic [7:0]           wb_adr_in,
   input wire logic [3:0]           wb_sel_in,
   input wire logic [31:0]          wb_dat_in,
   input wire logic [31:0]          wb_dat_out,
   input wire logic                 wb_ack_out,
   input wire logic                 smp_valid_in,
   input wire logic                 smp_ready_out,
   input wire dpd_pkg::dpd_stereo_t smp_out,
   input wire logic                 smp_valid_out,
   input wire logic                 smp_ready_in,
   input wire logic                 sloping_stopband_select_out
);
   logic take;
   logic left_on_reg;
   logic right_on_reg;
   logic mute_reg;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   assign take = wb_cyc_in && wb_stb_in && !wb_ack_out;
   sequence wr_hi(a); take && wb_we_in && wb_sel_in[1] && wb_adr_in == a; endsequence
   sequence rd(a); take && !wb_we_in && wb_adr_in == a; endsequence
   // one shadow per enable fed by both aliases
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         left_on_reg <= 1'b0;
         right_on_reg <= 1'b0;
         mute_reg <= 1'b1;
      end else if (take && wb_we_in) begin
         if (wb_adr_in == 8'h2c && wb_sel_in[0]) begin
            left_on_reg <= wb_dat_in[4];
            right_on_reg <= wb_dat_in[5];
         end
         if (wb_adr_in == 8'hc8 && wb_sel_in[1]) left_on_reg <= wb_dat_in[15];
         if (wb_adr_in == 8'hcc && wb_sel_in[1]) right_on_reg <= wb_dat_in[15];
         if (wb_adr_in == 8'he8 && wb_sel_in[1]) mute_reg <= wb_dat_in[14];
      end
   end
   bus_answer_a: assert property (take |=> wb_ack_out)
      else $error("request not acked");
   ack_single_a: assert property (wb_ack_out |=> !wb_ack_out)
      else $error("ack too long");
   read_data_a: assert property (wb_dat_out[31:16] == 16'h0 && (wb_ack_out || wb_dat_out == 32'h0))
      else $error("stray read data");
   power_alias_a: assert property (rd(8'h2c) |=> wb_dat_out[5:4] == {right_on_reg, left_on_reg})
      else $error("power enables wrong");
   vol_alias_a: assert property (rd(8'hc8) |=> wb_dat_out[15] == left_on_reg)
      else $error("volume enable mirror wrong");
   mute_read_a: assert property (rd(8'he8) |=> wb_dat_out[14] == mute_reg)
      else $error("soft mute read wrong");
   stopband_a: assert property (wr_hi(8'hec) |=> sloping_stopband_select_out == $past(wb_dat_in[12]))
      else $error("stopband select wrong");
   conv_off_a: assert property (smp_valid_out && !right_on_reg |-> smp_out.right == 24'h0)
      else $error("disabled channel not zero");
   out_hold_a: assert property (smp_valid_out && !smp_ready_in |=> smp_valid_out && $stable(smp_out))
      else $error("stalled output changed");
   take_out_a: assert property (smp_valid_in && smp_ready_out |=> smp_valid_out)
      else $error("taken pair not offered");
endmodule : dpd_playback_path_asserts
bind dpd_playback_path dpd_playback_path_asserts dpd_playback_path_asserts_i (
   .clk_in(clk_in), .resetn_in(resetn_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
   .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
   .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .smp_valid_in(smp_valid_in),
   .smp_ready_out(smp_ready_out), .smp_out(smp_out), .smp_valid_out(smp_valid_out),
   .smp_ready_in(smp_ready_in), .sloping_stopband_select_out(sloping_stopband_select_out));

/* File: testbench/dpd_src_model.sv */
// audio interface stand-in: one stereo pair at a time
`timescale 1ns/10ps
module dpd_src_model (
   input  wire logic            clk_in,
   output dpd_pkg::dpd_stereo_t smp_out,
   output logic                 smp_valid_out,
   input  wire logic            smp_ready_in
);
   initial begin
      smp_out = 48'h0;
      smp_valid_out = 1'b0;
   end
   // pair held until taken; idle data inverted so stale data shows
   task automatic push(input dpd_pkg::dpd_stereo_t p);
      smp_out <= p;
      smp_valid_out <= 1'b1;
      @(posedge clk_in);
      while (smp_ready_in !== 1'b1) @(posedge clk_in);
      smp_valid_out <= 1'b0;
      smp_out <= ~p;
   endtask : push
endmodule : dpd_src_model

/* File: testbench/dpd_playback_path_tb.sv */
// self-checking bench for the playback path
`timescale 1ns/10ps
module dpd_playback_path_tb;
   logic                 clk_in = 1'b0;
   logic                 resetn_in = 1'b0;
   logic                 wb_cyc_in = 1'b0;
   logic                 wb_stb_in = 1'b0;
   logic                 wb_we_in = 1'b0;
   logic [7:0]           wb_adr_in = 8'h00;
   logic [3:0]           wb_sel_in = 4'h0;
   logic [31:0]          wb_dat_in = 32'h0;
   logic [31:0]          wb_dat_out;
   logic                 wb_ack_out;
   logic                 smp_valid_in;
   logic                 smp_ready_out;
   logic                 smp_valid_out;
   logic                 smp_ready_in = 1'b1;
   logic                 stop_sel;
   dpd_pkg::dpd_stereo_t smp_in;
   dpd_pkg::dpd_stereo_t smp_out;
   dpd_pkg::dpd_stereo_t pr = {24'h100000, 24'h040000};
   dpd_pkg::dpd_stereo_t o;
   logic [31:0]          r;
   int                   n_fail = 0;
   int                   num_checks = 0;
   int                   cycles = 0;
   dpd_playback_path dpd_playback_path_i (
      .clk_in(clk_in), .resetn_in(resetn_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
      .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
      .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .smp_in(smp_in),
      .smp_valid_in(smp_valid_in), .smp_ready_out(smp_ready_out), .smp_out(smp_out),
      .smp_valid_out(smp_valid_out), .smp_ready_in(smp_ready_in),
      .sloping_stopband_select_out(stop_sel));
   dpd_src_model dpd_src_model_i (.clk_in(clk_in), .smp_out(smp_in),
      .smp_valid_out(smp_valid_in), .smp_ready_in(smp_ready_out));
   always #50 clk_in = ~clk_in;
   // the run needs some 1300 cycles; far more is a hang
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         end_sim();
      end
   end
   task automatic end_sim();
      if (n_fail == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // classic single cycle, held until ack
   task automatic wb(input logic we, input logic [7:0] a, input logic [15:0] d);
      wb_cyc_in <= 1'b1;
      wb_stb_in <= 1'b1;
      wb_we_in <= we;
      wb_adr_in <= a;
      wb_sel_in <= 4'h3;
      wb_dat_in <= {16'h0, d};
      @(posedge clk_in);
      while (wb_ack_out !== 1'b1) @(posedge clk_in);
      r = wb_dat_out;
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
      @(posedge clk_in);
   endtask : wb
   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
      wb(1'b0, a, 16'h0);
      chk(nm, e, r);
   endtask : rdc
   // receiver: takes the pair where valid and ready meet
   task automatic get();
      @(posedge clk_in);
      while (!(smp_valid_out === 1'b1 && smp_ready_in === 1'b1)) @(posedge clk_in);
      o = smp_out;
   endtask : get
   task automatic xfer(input dpd_pkg::dpd_stereo_t p);
      dpd_src_model_i.push(p);
      get();
   endtask : xfer
   task automatic ckp(input string nm, input logic [23:0] el, input logic [23:0] er);
      chk(nm, {8'h0, el}, {8'h0, o.left});
      chk(nm, {8'h0, er}, {8'h0, o.right});
   endtask : ckp
   task automatic t_reset();
      rdc(8'he8, 32'h4000, "mute_rst");
      rdc(8'hc8, 32'h00c0, "vol_rst");
      wb(1'b1, 8'hfc, 16'hffff);
      rdc(8'hfc, 32'h0, "unmapped");
      wb(1'b1, 8'h2c, 16'h0030);
      xfer(pr);
      ckp("muted_rst", 24'h0, 24'h0);
   endtask : t_reset
   task automatic t_enable();
      rdc(8'hc8, 32'h80c0, "vol_alias");
      wb(1'b1, 8'hcc, 16'h00c0);
      rdc(8'h2c, 32'h0010, "power_alias");
      wb(1'b1, 8'hcc, 16'h80c0);
      wb(1'b1, 8'he8, 16'h0000);
      xfer(pr);
      ckp("unmute_jump", pr.left, pr.right);
   endtask : t_enable
   task automatic t_volume();
      wb(1'b1, 8'hc8, 16'h8000);
      rdc(8'hc8, 32'h8000, "vol_pend_rd");
      xfer(pr);
      ckp("vol_pending", pr.left, pr.right);
      wb(1'b1, 8'hcc, 16'h81c0);
      rdc(8'hf0, 32'hc000, "gain_commit");
      xfer(pr);
      ckp("vol_zero", 24'h0, pr.right);
      wb(1'b1, 8'hc8, 16'h81c0);
   endtask : t_volume
   task automatic t_mix();
      wb(1'b1, 8'hc0, 16'h0002);
      xfer(pr);
      ckp("flip_l", -pr.left, pr.right);
      wb(1'b1, 8'hc0, 16'h0001);
      xfer(pr);
      ckp("flip_r", pr.left, -pr.right);
      wb(1'b1, 8'hc0, 16'h2000);
      xfer(pr);
      ckp("mono", 24'h0a0000, 24'h0a0000);
      wb(1'b1, 8'h2c, 16'h0010);
      xfer(pr);
      ckp("mono_one_on", pr.left, 24'h0);
      wb(1'b1, 8'h2c, 16'h0030);
   endtask : t_mix
   task automatic t_modes();
      for (int d = 0; d < 4; d++) begin
         wb(1'b1, 8'hc0, 16'(d * 16));
         rdc(8'hc0, 32'(d * 16), "emphasis_undo_select_field");
      end
      wb(1'b1, 8'hc0, 16'h0000);
      xfer(pr);
      ckp("emphasis_undo_select_off", pr.left, pr.right);
      wb(1'b1, 8'hec, 16'h1000);
      @(negedge clk_in);
      chk("stopband", 32'h1, {31'h0, stop_sel});
      @(posedge clk_in);
      wb(1'b1, 8'hec, 16'h0000);
   endtask : t_modes
   // ramp steps follow taken samples, not clocks
   task automatic t_ramp();
      wb(1'b1, 8'he8, 16'h4000);
      repeat (4) xfer(pr);
      chk("ramp_gradual", 32'h1, {31'h0, o.left > 24'sh0 && o.left < pr.left});
      repeat (36) xfer(pr);
      wb(1'b0, 8'hf4, 16'h0);
      chk("fast_rate", 32'h1, {31'h0, r[8:0] >= 9'h0ea && r[8:0] <= 9'h0ee});
      repeat (480) xfer(pr);
      ckp("ramp_silent", 24'h0, 24'h0);
      rdc(8'hf4, 32'h0800, "silent_state");
      wb(1'b1, 8'hec, 16'h6000);
      wb(1'b1, 8'he8, 16'h0000);
      repeat (40) xfer(pr);
      wb(1'b0, 8'hf4, 16'h0);
      chk("slow_up", 32'h1, {31'h0, r[12:9] == 4'h8 && r[8:0] <= 9'h003 && r[8:0] > 9'h000});
      wb(1'b1, 8'hec, 16'h0000);
      wb(1'b1, 8'he8, 16'h4000);
      wb(1'b1, 8'he8, 16'h0000);
      rdc(8'hf4, 32'h0300, "instant_full");
   endtask : t_ramp
   task automatic t_buffer();
      dpd_pkg::dpd_stereo_t q = {24'h000123, 24'h000456};
      smp_ready_in <= 1'b0;
      dpd_src_model_i.push(pr);
      @(posedge clk_in);
      dpd_src_model_i.push(q);
      @(negedge clk_in);
      chk("buf_full", 32'h0, {31'h0, smp_ready_out});
      @(posedge clk_in);
      smp_ready_in <= 1'b1;
      get();
      ckp("buf_first", pr.left, pr.right);
      get();
      ckp("buf_second", q.left, q.right);
   endtask : t_buffer
   initial begin
      repeat (16) @(posedge clk_in);
      resetn_in <= 1'b1;
      @(posedge clk_in);
      t_reset();
      t_enable();
      t_volume();
      t_mix();
      t_modes();
      t_ramp();
      t_buffer();
      end_sim();
   end
endmodule : dpd_playback_path_tb
